//--- verilog/waveform_defines.vh
`ifndef WAVEFORM_DEFINES_VH
`define WAVEFORM_DEFINES_VH
// ************************************************
// waveform control fields
// ************************************************
`define FC_ENABLE 7
`define FC_BIPOLAR 6
`define FC_CONTIN 5
`define FC_SYMM 4
`define FC_DEPTH_HI 3
`define FC_DEPTH_LO 0
`define FC_RESET 8'h00
// ************************************************
// dac control fields
// ************************************************
`define DC_DAC_EN 0
`define DC_REF_EN 1
`define DC_REFSEL_HI 7
`define DC_REFSEL_LO 6
`define DC_RESET 8'h00
// ************************************************
// direct write commands (upper nibble)
// ************************************************
`define DW_BOTH 4'h4
`define DW_INPUT 4'h1
`define DAC_RESET 12'h000
// ************************************************
// switch control fields
// ************************************************
`define SW_CHG1 0
`define SW_CHG2 1
`define SW_GANG 2
`define SW_FB_C 5
`define SW_FB_B 6
`define SW_FB_A 7
`define SW_RESET 8'h00
// ************************************************
// pin modes (three bits per pin, four-bit pitch)
// ************************************************
`define PM_OFF 3'h0
`define PM_CHG1 3'h1
`define PM_CHG2 3'h2
`define PM_FB_A 3'h3
`define PM_FB_B 3'h4
`define PM_FB_C 3'h5
`define PM_STEP 3'h7
`define PC_RESET 16'h0000
`endif

//--- verilog/dac_waveform_fifo_and_switch_ctl.v
`timescale 1ns/10ps
`default_nettype none
`include "waveform_defines.vh"
module dac_waveform_fifo_and_switch_ctl #(
    parameter DEPTH = 16,
    parameter PINS = 4
) (
    input wire core_clk,
    input wire reset,
    input wire fifoCtlWrite, // one-cycle strobe
    input wire [7:0] fifoCtlData,
    input wire fifoBitValid, // one data bit per strobe
    input wire fifoBit,
    input wire pinCtlWrite,
    input wire [15:0] pinCtlData,
    input wire dacCtlWrite,
    input wire [7:0] dacCtlData,
    input wire directWrite,
    input wire [15:0] directData,
    input wire swCtlWrite,
    input wire [7:0] swCtlData,
    input wire [PINS-1:0] digitalPins, // asynchronous pins
    output reg [11:0] dacOutCode_r,
    output reg [11:0] dacInput_r,
    output reg dacEnable_r,
    output reg refEnable_r,
    output reg [1:0] refSelect_r,
    output reg chgSwitchOne_r,
    output reg chgSwitchTwo_r,
    output reg fbSwitchA_r,
    output reg fbSwitchB_r,
    output reg fbSwitchC_r,
    output reg [7:0] fifoCtl_r,
    output reg sequencing_r // high while a period is being played
);
    // ************************************************
    // state
    // ************************************************
    reg [11:0] fifoMem_r [0:DEPTH-1]; // first-quarter offsets
    reg [15:0] shift_r; // incoming word, msb first
    reg [3:0] bitCount_r;
    reg [3:0] wordIdx_r; // next entry to fill
    reg [15:0] pinCtl_r;
    reg [7:0] swCtl_r;
    reg [PINS-1:0] pinMeta_r; // first sync stage
    reg [PINS-1:0] pinSync_r; // second sync stage
    reg stepPrev_r;
    reg [3:0] pos_r; // position within quarter
    reg [1:0] quarter_r;
    reg started_r; // initial value loaded since enable
    // ************************************************
    // combinational helpers
    // ************************************************
    wire [3:0] last = fifoCtl_r[`FC_DEPTH_HI:`FC_DEPTH_LO]; // depth minus one
    wire enabled = fifoCtl_r[`FC_ENABLE];
    wire stepMode = (pinCtl_r[2:0] == `PM_STEP);
    wire stepEdge = stepMode && pinSync_r[0] && !stepPrev_r;
    wire [15:0] nextWord = {shift_r[14:0], fifoBit};
    reg [11:0] offset;
    reg negate;
    reg [12:0] sample;
    reg [3:0] posNxt;
    reg [1:0] quarterNxt;
    reg periodEnd;
    // offset for the current position and quarter
    always @* begin
        offset = fifoMem_r[pos_r];
        negate = 1'b0;
        if (fifoCtl_r[`FC_SYMM]) begin
            // reverse quarters walk back, ending on zero offset
            if (quarter_r[0]) begin
                offset = (pos_r == last) ? 12'h000 : fifoMem_r[last - 4'h1 - pos_r];
            end
            negate = quarter_r[1];
        end
        // signed offset in bipolar mode, unsigned otherwise
        if (fifoCtl_r[`FC_BIPOLAR]) begin
            sample = negate ? {1'b0, dacInput_r} - {offset[11], offset}
                            : {1'b0, dacInput_r} + {offset[11], offset};
        end else begin
            sample = negate ? {1'b0, dacInput_r} - {1'b0, offset}
                            : {1'b0, dacInput_r} + {1'b0, offset};
        end
    end
    // step position through quarters
    always @* begin
        posNxt = pos_r + 4'h1;
        quarterNxt = quarter_r;
        periodEnd = 1'b0;
        if (pos_r == last) begin
            posNxt = 4'h0;
            if (!fifoCtl_r[`FC_SYMM] || quarter_r == 2'h3) begin
                quarterNxt = 2'h0;
                periodEnd = 1'b1;
            end else begin
                quarterNxt = quarter_r + 2'h1;
            end
        end
    end
    // ************************************************
    // pin synchroniser
    // ************************************************
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pinMeta_r <= {PINS{1'b0}};
            pinSync_r <= {PINS{1'b0}};
            stepPrev_r <= 1'b0;
        end else begin
            pinMeta_r <= digitalPins;
            pinSync_r <= pinMeta_r;
            stepPrev_r <= pinSync_r[0];
        end
    end
    // ************************************************
    // control registers
    // ************************************************
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fifoCtl_r <= `FC_RESET;
            pinCtl_r <= `PC_RESET;
            swCtl_r <= `SW_RESET;
            dacEnable_r <= 1'b0;
            refEnable_r <= 1'b0;
            refSelect_r <= 2'b00;
        end else begin
            if (fifoCtlWrite) begin
                fifoCtl_r <= fifoCtlData;
            end
            if (pinCtlWrite) begin
                pinCtl_r <= pinCtlData;
            end
            if (swCtlWrite) begin
                swCtl_r <= swCtlData;
            end
            // dac enable, reference enable, reference select
            if (dacCtlWrite) begin
                dacEnable_r <= dacCtlData[`DC_DAC_EN];
                refEnable_r <= dacCtlData[`DC_REF_EN];
                refSelect_r <= dacCtlData[`DC_REFSEL_HI:`DC_REFSEL_LO];
            end
        end
    end
    // ************************************************
    // serial fifo load
    // ************************************************
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            shift_r <= 16'h0000;
            bitCount_r <= 4'h0;
            wordIdx_r <= 4'h0;
        end else if (fifoCtlWrite) begin
            // any fifo control write restarts the stream at entry 0
            bitCount_r <= 4'h0;
            wordIdx_r <= 4'h0;
        end else if (fifoBitValid && !enabled) begin
            shift_r <= nextWord;
            bitCount_r <= bitCount_r + 4'h1;
            if (bitCount_r == 4'hF) begin
                wordIdx_r <= wordIdx_r + 4'h1;
            end
        end
    end
    // entry write, low four bits dropped
    always @(posedge core_clk) begin
        if (fifoBitValid && !enabled && !fifoCtlWrite && bitCount_r == 4'hF) begin
            fifoMem_r[wordIdx_r] <= nextWord[15:4];
        end
    end
    // ************************************************
    // dac registers and sequencer
    // ************************************************
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dacInput_r <= `DAC_RESET;
            dacOutCode_r <= `DAC_RESET;
            pos_r <= 4'h0;
            quarter_r <= 2'h0;
            started_r <= 1'b0;
            sequencing_r <= 1'b0;
        end else begin
            // idle: next period starts from the initial value, even during a direct write
            if (!enabled) begin
                pos_r <= 4'h0;
                quarter_r <= 2'h0;
                started_r <= 1'b0;
                sequencing_r <= 1'b0;
            end
            if (directWrite && directData[15:12] == `DW_BOTH) begin
                dacInput_r <= directData[11:0];
                dacOutCode_r <= directData[11:0];
            end else if (directWrite && directData[15:12] == `DW_INPUT) begin
                dacInput_r <= directData[11:0];
            end else if (enabled && !started_r) begin
                dacOutCode_r <= dacInput_r;
                started_r <= 1'b1;
                sequencing_r <= 1'b1;
            end else if (enabled && stepEdge && sequencing_r) begin
                dacOutCode_r <= sample[11:0];
                pos_r <= posNxt;
                quarter_r <= quarterNxt;
                if (periodEnd && !fifoCtl_r[`FC_CONTIN]) begin
                    sequencing_r <= 1'b0;
                end
            end
        end
    end
    // ************************************************
    // analog switch controls
    // ************************************************
    reg [4:0] pinDrive; // chg1, chg2, fbA, fbB, fbC from pins
    reg [2:0] mode;
    integer i;
    always @* begin
        pinDrive = 5'b00000;
        mode = `PM_OFF;
        for (i = 0; i < PINS; i = i + 1) begin
            mode = pinCtl_r[4*i +: 3];
            if (pinSync_r[i]) begin
                if (mode == `PM_CHG1) pinDrive[0] = 1'b1;
                if (mode == `PM_CHG2) pinDrive[1] = 1'b1;
                if (mode == `PM_FB_A) pinDrive[2] = 1'b1;
                if (mode == `PM_FB_B) pinDrive[3] = 1'b1;
                if (mode == `PM_FB_C) pinDrive[4] = 1'b1;
            end
        end
    end
    wire chg1 = swCtl_r[`SW_CHG1] | pinDrive[0];
    wire chg2 = swCtl_r[`SW_CHG2] | pinDrive[1];
    wire gang = swCtl_r[`SW_GANG];
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            chgSwitchOne_r <= 1'b0;
            chgSwitchTwo_r <= 1'b0;
            fbSwitchA_r <= 1'b0;
            fbSwitchB_r <= 1'b0;
            fbSwitchC_r <= 1'b0;
        end else begin
            // ganged: either control moves both changeovers
            chgSwitchOne_r <= gang ? (chg1 | chg2) : chg1;
            chgSwitchTwo_r <= gang ? (chg1 | chg2) : chg2;
            fbSwitchA_r <= swCtl_r[`SW_FB_A] | pinDrive[2];
            fbSwitchB_r <= swCtl_r[`SW_FB_B] | pinDrive[3];
            fbSwitchC_r <= swCtl_r[`SW_FB_C] | pinDrive[4];
        end
    end
endmodule
`default_nettype wire

//--- verification/wave_ctl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module wave_ctl_chk #(
    parameter DEPTH = 16,
    parameter PINS = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic fifoCtlWrite,
    input wire logic [7:0] fifoCtlData,
    input wire logic dacCtlWrite,
    input wire logic [7:0] dacCtlData,
    input wire logic directWrite,
    input wire logic [15:0] directData,
    input wire logic swCtlWrite,
    input wire logic [7:0] swCtlData,
    input wire logic [11:0] dacOutCode_r,
    input wire logic [11:0] dacInput_r,
    input wire logic dacEnable_r,
    input wire logic refEnable_r,
    input wire logic [1:0] refSelect_r,
    input wire logic chgSwitchOne_r,
    input wire logic chgSwitchTwo_r,
    input wire logic fbSwitchA_r,
    input wire logic [7:0] fifoCtl_r,
    input wire logic sequencing_r
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // gang write with one changeover asked closed
    sequence gangWr_s;
        swCtlWrite && swCtlData[2] && (swCtlData[0] || swCtlData[1]);
    endsequence
    // first enabled cycle, no direct write competing
    sequence seqStart_s;
        $rose(fifoCtl_r[7]) && !directWrite;
    endsequence
    dac_ctl_a: assert property (dacCtlWrite |=> {refSelect_r, refEnable_r, dacEnable_r} ==
        {$past(dacCtlData[7:6]), $past(dacCtlData[1:0])}) else $error("dac control");
    fifo_ctl_a: assert property (fifoCtlWrite |=> fifoCtl_r == $past(fifoCtlData))
        else $error("fifo control");
    direct_both_a: assert property (directWrite && directData[15:12] == 4'h4 |=>
        dacOutCode_r == $past(directData[11:0]) && dacInput_r == dacOutCode_r)
        else $error("direct both");
    direct_input_a: assert property (directWrite && directData[15:12] == 4'h1 |=>
        dacInput_r == $past(directData[11:0])) else $error("direct input");
    seq_start_a: assert property (seqStart_s |=> sequencing_r &&
        dacOutCode_r == $past(dacInput_r)) else $error("start sample");
    seq_idle_a: assert property (!fifoCtl_r[7] ##1 !fifoCtl_r[7] |-> !sequencing_r)
        else $error("idle playing");
    out_cause_a: assert property ($changed(dacOutCode_r) |->
        $past(directWrite) || $past(fifoCtl_r[7])) else $error("output moved");
    fb_close_a: assert property (swCtlWrite && swCtlData[7] |-> ##2 fbSwitchA_r)
        else $error("feedback switch");
    gang_both_a: assert property (gangWr_s |-> ##2 chgSwitchOne_r && chgSwitchTwo_r)
        else $error("gang mode");
endmodule
bind dac_waveform_fifo_and_switch_ctl wave_ctl_chk #(.DEPTH(DEPTH), .PINS(PINS)) CHK (.*);
`default_nettype wire

//--- verification/step_clk_src.sv
`timescale 1ns/10ps
`default_nettype none
module step_clk_src #(
    parameter HALF = 400
) (
    input wire logic run,
    output var logic stepPin
);
    // step clock, low and still while not running
    initial begin
        stepPin = '0;
        #37;
        forever begin
            #(HALF);
            stepPin = run ? ~stepPin : '0;
        end
    end
endmodule
`default_nettype wire

//--- verification/dac_waveform_fifo_and_switch_ctl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dac_waveform_fifo_and_switch_ctl_tb_top;
    logic core_clk = '0, reset = '1, run = '0, fifoBitValid = '0, fifoBit = '0;
    logic fifoCtlWrite = '0, pinCtlWrite = '0, dacCtlWrite = '0;
    logic directWrite = '0, swCtlWrite = '0, stepPin;
    logic [7:0] fifoCtlData = '0, dacCtlData = '0, swCtlData = '0, fifoCtl_r, d;
    logic [15:0] pinCtlData = '0, directData = '0;
    logic [2:0] pinHi = '0; // pins 3..1
    wire logic [3:0] digitalPins = {pinHi, stepPin};
    logic [11:0] dacOutCode_r, dacInput_r;
    logic dacEnable_r, refEnable_r, chgSwitchOne_r, chgSwitchTwo_r;
    logic fbSwitchA_r, fbSwitchB_r, fbSwitchC_r, sequencing_r;
    logic [1:0] refSelect_r;
    int n_fail = 0, n_compared = 0;
    // quarter-wave table, offset in the upper twelve bits
    logic [15:0] wave [16] = '{16'h0A10, 16'h1400, 16'h1DC0, 16'h2730, 16'h3040, 16'h38E0,
        16'h40F0, 16'h4870, 16'h4F30, 16'h5520, 16'h5A50, 16'h5EA0, 16'h6200, 16'h6470,
        16'h65F0, 16'h6660};
    logic [7:0] swTab [7] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h80, 8'h40, 8'h20};
    dac_waveform_fifo_and_switch_ctl DUT (.*);
    step_clk_src PARTNER (.run(run), .stepPin(stepPin));
    always #50 core_clk = ~core_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // k: 0 fifo ctl, 1 pin ctl, 2 dac ctl, 3 direct, 4 switch ctl
    task automatic wr(input int k, input logic [15:0] v);
        @(posedge core_clk);
        {fifoCtlData, dacCtlData, swCtlData} <= {3{v[7:0]}};
        {pinCtlData, directData} <= {v, v};
        {swCtlWrite, directWrite, dacCtlWrite, pinCtlWrite, fifoCtlWrite} <= 5'h1 << k;
        @(posedge core_clk);
        {swCtlWrite, directWrite, dacCtlWrite, pinCtlWrite, fifoCtlWrite} <= '0;
    endtask
    // one word, msb first
    task automatic putWord(input logic [15:0] w);
        for (int b = 15; b >= 0; b--) begin
            @(posedge core_clk);
            fifoBitValid <= '1;
            fifoBit <= w[b];
        end
    endtask
    task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask
    // offset of step k: forward, reverse, negated forward, negated reverse
    function automatic logic [11:0] offs(input int k);
        int i;
        logic [11:0] f;
        i = k % 16;
        f = (k % 32 < 16) ? wave[i][15:4] : (i < 15 ? wave[14 - i][15:4] : '0);
        return (k % 64 < 32) ? f : -f;
    endfunction
    task automatic print_verdict;
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #1000000;
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= '0;
        tick(1);
        chk("reset", '0, {fifoCtl_r, sequencing_r});
        wr(2, 16'h0043);
        tick(1);
        chk("dacctl", 12'h007, {refSelect_r, refEnable_r, dacEnable_r});
        wr(3, 16'h4800);
        tick(1);
        chk("dacout", 12'h800, dacOutCode_r);
        chk("dacin", 12'h800, dacInput_r);
        wr(0, 16'h007F);
        foreach (wave[w]) putWord(wave[w]);
        @(posedge core_clk);
        fifoBitValid <= '0;
        wr(0, 16'h00FF);
        putWord(16'hFFFF); // refused while enabled
        @(posedge core_clk);
        fifoBitValid <= '0;
        #1;
        chk("ctl", 12'h0FF, fifoCtl_r);
        chk("start", 12'h800, dacOutCode_r);
        wr(1, 16'h0007);
        wr(4, 16'h0080);
        tick(3);
        chk("fbA", 12'h001, fbSwitchA_r);
        run <= '1;
        for (int k = 0; k < 65; k++) begin
            @(posedge stepPin);
            tick(6);
            chk("step", 12'h800 + offs(k), dacOutCode_r);
        end
        run <= '0;
        wr(1, 16'h3147);
        foreach (swTab[j]) begin
            d = swTab[j];
            wr(4, d);
            tick(3);
            chk("sw", {d[7:5], d[1] | d[2] & d[0], d[0] | d[2] & d[1]},
                {fbSwitchA_r, fbSwitchB_r, fbSwitchC_r, chgSwitchTwo_r, chgSwitchOne_r});
        end
        for (int v = 1; v >= 0; v--) begin
            @(posedge core_clk);
            pinHi <= {3{1'(v)}};
            tick(5);
            chk("pins", {3{1'(v)}}, {fbSwitchA_r, fbSwitchB_r, chgSwitchOne_r});
        end
        // single shot, unipolar, plain quarter of depth four from a new input value
        wr(3, 16'h1400);
        wr(0, 16'h0003);
        wr(0, 16'h0083);
        tick(2);
        chk("start2", 12'h400, dacOutCode_r);
        run <= '1;
        for (int k = 0; k < 5; k++) begin
            @(posedge stepPin);
            tick(6);
            chk("shot", 12'h400 + wave[k < 4 ? k : 3][15:4], dacOutCode_r);
            chk("busy", 12'(k < 3), sequencing_r);
        end
        run <= '0;
        print_verdict;
    end
endmodule
`default_nettype wire
